// ### event_status_mask_unit.sv
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "event_status_mask_unit_map.svh"

module event_status_mask_unit #(
  parameter int ADDR_W = 24,
  parameter logic [31:0] IMPL_MASK = 32'hffffffff,
  parameter logic INBAND_REPORT = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] i_event,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  output logic o_irq,
  output logic o_msg_valid,
  output event_unit_pkg::message_t o_msg
);

  // Byte lanes to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Merge written lanes into an old value
  function automatic logic [31:0] merge_write(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [31:0] mask
  );
    return (old & ~mask) | (data & mask);
  endfunction

  event_unit_pkg::bus_state_t state_reg;
  event_unit_pkg::bus_state_t state_next;
  event_unit_pkg::setup_t setup_view;
  event_unit_pkg::message_t msg_next;
  logic [31:0] raw_reg;
  logic [31:0] raw_next;
  logic [31:0] enable_reg;
  logic [31:0] enable_next;
  logic [31:0] repeat_reg;
  logic [31:0] repeat_next;
  logic [31:0] setup_reg;
  logic [31:0] setup_next;
  logic [31:0] cause_next;
  logic [31:0] rd_mux;
  logic ack_reg;
  logic ack_next;
  logic irq_next;
  logic msg_valid_next;
  logic hit_raw;
  logic hit_enable;
  logic hit_trigger;
  logic hit_cause;
  logic hit_repeat;
  logic hit_setup;

  // Bus request and the edge where it completes
  wire req = i_wb_cyc & i_wb_stb;
  wire take = req & ack_reg;
  wire wr = take & i_wb_we;
  wire [31:0] wmask = lane_mask(i_wb_sel);
  wire [31:0] cause_now = raw_reg & enable_reg;

  // Address decode; unmapped offsets still ack and read zero
  always_comb begin
    hit_raw = 1'b0;
    hit_enable = 1'b0;
    hit_trigger = 1'b0;
    hit_cause = 1'b0;
    hit_repeat = 1'b0;
    hit_setup = 1'b0;
    if (i_wb_adr == ADDR_W'(`OFF_RAW_STATE)) begin
      hit_raw = 1'b1;
    end else if (i_wb_adr == ADDR_W'(`OFF_MASK_ENABLE)) begin
      hit_enable = 1'b1;
    end else if (i_wb_adr == ADDR_W'(`OFF_SW_TRIGGER)) begin
      hit_trigger = 1'b1;
    end else if (i_wb_adr == ADDR_W'(`OFF_MASKED_STATE)) begin
      hit_cause = 1'b1;
    end else if (i_wb_adr == ADDR_W'(`OFF_REPEAT_FLAG)) begin
      hit_repeat = 1'b1;
    end else if (i_wb_adr == ADDR_W'(`OFF_MSG_SETUP)) begin
      hit_setup = 1'b1;
    end
  end

  // Per register write strobes
  wire wr_raw = wr & hit_raw;
  wire wr_enable = wr & hit_enable;
  wire wr_trigger = wr & hit_trigger;
  wire wr_cause = wr & hit_cause;
  wire wr_repeat = wr & hit_repeat;
  wire wr_setup = wr & hit_setup;

  // Read selection; trigger has no storage behind it
  assign rd_mux = hit_raw ? raw_reg :
                  hit_enable ? enable_reg :
                  hit_cause ? cause_now :
                  hit_repeat ? repeat_reg :
                  hit_setup ? setup_reg :
                  `RST_WORD;

  // Software trigger only passes where enabled
  wire [31:0] force_ev = wr_trigger ?
    (i_wb_dat & wmask & enable_reg) : `RST_WORD;

  // Hardware and forced events, reserved positions dropped
  wire [31:0] ev_in = (i_event | force_ev) & IMPL_MASK;

  // Written zero lanes clear; cause writes clear the raw bit too
  wire [31:0] clear_raw =
    ((wr_raw | wr_cause) ? (wmask & ~i_wb_dat) : `RST_WORD);
  wire [31:0] clear_repeat =
    (wr_repeat ? (wmask & ~i_wb_dat) : `RST_WORD);

  // Event on an already set bit that is not being cleared
  wire [31:0] again = ev_in & raw_reg & ~clear_raw;

  // Set wins over clear so no event is lost
  assign raw_next = ((raw_reg & ~clear_raw) | ev_in) & IMPL_MASK;
  assign repeat_next =
    ((repeat_reg & ~clear_repeat) | again) & IMPL_MASK;

  // Enable and setup merge under byte lanes
  assign enable_next = wr_enable ?
    (merge_write(enable_reg, i_wb_dat, wmask) & IMPL_MASK) :
    enable_reg;
  assign setup_next = wr_setup ?
    (merge_write(setup_reg, i_wb_dat, wmask) & `SETUP_WRITE_MASK) :
    setup_reg;

  // Masked view drives the interrupt, aligned with the registers
  assign cause_next = raw_next & enable_next;
  assign irq_next = |cause_next;

  // Message request on enabled events only
  assign setup_view = event_unit_pkg::setup_t'(setup_reg);
  wire [31:0] msg_events = ev_in & enable_reg;
  assign msg_valid_next = INBAND_REPORT & setup_view.msg_enable &
                          (|msg_events);
  assign msg_next.events = msg_events;
  assign msg_next.dest_id = setup_view.dest_id;
  assign msg_next.large_transport = setup_view.large_transport;

  // Single ack per request, dropped in the following cycle
  assign state_next = (state_reg == event_unit_pkg::BUS_IDLE && req) ?
    event_unit_pkg::BUS_ACK : event_unit_pkg::BUS_IDLE;
  assign ack_next = (state_next == event_unit_pkg::BUS_ACK);

  // Bus handshake and read data
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= event_unit_pkg::BUS_IDLE;
      ack_reg <= 1'b0;
      o_wb_dat <= `RST_WORD;
    end else begin
      state_reg <= state_next;
      ack_reg <= ack_next;
      if (ack_next) begin
        o_wb_dat <= rd_mux;
      end
    end
  end

  assign o_wb_ack = ack_reg;

  // Event and control registers
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      raw_reg <= `RST_RAW_STATE;
      enable_reg <= `RST_MASK_ENABLE;
      repeat_reg <= `RST_REPEAT_FLAG;
      setup_reg <= `RST_MSG_SETUP;
    end else begin
      raw_reg <= raw_next;
      enable_reg <= enable_next;
      repeat_reg <= repeat_next;
      setup_reg <= setup_next;
    end
  end

  // Interrupt and message outputs straight from flops
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
      o_msg_valid <= 1'b0;
      o_msg <= '0;
    end else begin
      o_irq <= irq_next;
      o_msg_valid <= msg_valid_next;
      o_msg <= msg_next;
    end
  end

  // Helper views for the checks below
  wire [31:0] ev_impl = i_event & IMPL_MASK;
  wire rd_start = req & ~ack_reg & ~i_wb_we;
  wire [31:0] force_impl = force_ev & IMPL_MASK;

  // Every implemented event lands in raw state
  raw_sets_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    1'b1 |=> ((raw_reg & $past(ev_impl)) == $past(ev_impl))
  ) else $error("event did not set raw state");

  // Zero write clears when nothing else arrives
  raw_clears_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (wr_raw && ev_in == 32'h00000000) |=>
      (raw_reg == ($past(raw_reg) & ~$past(clear_raw)))
  ) else $error("zero write did not clear raw state");

  // Raw read returns the unmasked state
  raw_read_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (rd_start && hit_raw) |=> (o_wb_dat == $past(raw_reg))
  ) else $error("raw state read mismatch");

  // Full-word enable writes land with reserved bits dropped
  enable_write_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (wr_enable && i_wb_sel == 4'hf) |=>
      (enable_reg == ($past(i_wb_dat) & IMPL_MASK))
  ) else $error("enable register not written");

  // Forced enabled bits appear in raw state
  force_sets_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    wr_trigger |=>
      ((raw_reg & $past(force_impl)) == $past(force_impl))
  ) else $error("forced event not raised");

  // Forcing a masked bit raises nothing
  force_masked_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (wr_trigger && i_event == 32'h00000000 && !wr_enable) |=>
      (((raw_reg & ~$past(raw_reg)) & ~$past(enable_reg)) ==
       32'h00000000)
  ) else $error("masked force raised an event");

  // Trigger reads return zero
  force_read_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (rd_start && hit_trigger) |=> (o_wb_dat == 32'h00000000)
  ) else $error("trigger register read nonzero");

  // Masked read is raw gated by enable
  cause_read_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (rd_start && hit_cause) |=>
      (o_wb_dat == ($past(raw_reg) & $past(enable_reg)))
  ) else $error("masked state read mismatch");

  // Reserved positions never hold a one
  reserved_zero_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    ((raw_reg | enable_reg | repeat_reg) & ~IMPL_MASK) == 32'h00000000
  ) else $error("reserved bit set");

  // A repeat on a set bit marks the repeat flag
  repeat_mark_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (again != 32'h00000000) |=>
      ((repeat_reg & $past(again)) == $past(again))
  ) else $error("repeat flag missed");

  // Messages need the enable bit and an enabled event
  msg_gate_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_msg_valid |-> ($past(setup_view.msg_enable) &&
                     $past(msg_events) != 32'h00000000)
  ) else $error("message without enable");

  // Interrupt follows the masked state
  irq_level_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_irq == (|cause_now)
  ) else $error("interrupt level wrong");

  // Each request gets one ack, one cycle long
  ack_pulse_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (req && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack
  ) else $error("bus ack timing wrong");

  // No ack unless a request stood in the cycle before
  ack_needs_req_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (!req) |=> !o_wb_ack
  ) else $error("ack without request");

  // Zero write clears the repeat flag when nothing recurs
  repeat_clear_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (wr_repeat && again == 32'h00000000) |=>
      (repeat_reg == ($past(repeat_reg) & ~$past(clear_repeat)))
  ) else $error("repeat flag not cleared");

  // Enabled event shows in the masked view one cycle later
  cause_sets_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    !wr_enable |=> ((cause_now & $past(msg_events)) == $past(msg_events))
  ) else $error("enabled event missing from masked view");

  // Request carries the enabled events and the setup fields
  msg_fields_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_msg_valid |->
      (o_msg.events == $past(msg_events) &&
       o_msg.dest_id == $past(setup_view.dest_id) &&
       o_msg.large_transport == $past(setup_view.large_transport))
  ) else $error("message fields wrong");

  // No buffering, so a missed pulse is a lost message
  msg_raise_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (INBAND_REPORT && setup_view.msg_enable && msg_events != 32'h00000000)
      |=> o_msg_valid
  ) else $error("message request missing");

  // Setup bits outside its fields always read zero
  setup_spare_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (setup_reg & ~`SETUP_WRITE_MASK) == 32'h00000000
  ) else $error("setup reserved bit set");

endmodule

// ### event_status_mask_unit_map.svh
`ifndef EVENT_STATUS_MASK_UNIT_MAP_SVH
`define EVENT_STATUS_MASK_UNIT_MAP_SVH

// Byte addresses of the event registers
`define OFF_RAW_STATE 24'h106100
`define OFF_MASK_ENABLE 24'h106104
`define OFF_SW_TRIGGER 24'h106108
`define OFF_MASKED_STATE 24'h10610c
`define OFF_REPEAT_FLAG 24'h106110
`define OFF_MSG_SETUP 24'h106114

// Reset values
`define RST_RAW_STATE 32'h00000000
`define RST_MASK_ENABLE 32'h00000000
`define RST_REPEAT_FLAG 32'h00000000
`define RST_MSG_SETUP 32'h00000000
`define RST_WORD 32'h00000000

// Message setup field positions (bit 0 is the lsb)
`define SETUP_MSG_EN_BIT 0
`define SETUP_LARGE_BIT 1
`define SETUP_DEST_LSB 16
`define SETUP_DEST_MSB 31
`define SETUP_WRITE_MASK 32'hffff0003

// Bus answer latency in cycles
`define BUS_ACK_CYCLES 1

`endif

// ### event_status_mask_unit_tb.sv
`timescale 1ns/1ns
`include "event_status_mask_unit_map.svh"

module event_status_mask_unit_tb;
  logic i_mclk, i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [23:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, i_event, o_wb_dat;
  logic o_wb_ack, o_irq, o_msg_valid;
  event_unit_pkg::message_t o_msg;
  logic [31:0] rq[$];
  event_unit_pkg::message_t mq[$];
  int err_count, comparisons, seed;
  logic [31:0] r, m, c, t, e, raw;
  logic [23:0] regs [7] = '{`OFF_RAW_STATE, `OFF_MASK_ENABLE,
    `OFF_SW_TRIGGER, `OFF_MASKED_STATE, `OFF_REPEAT_FLAG, `OFF_MSG_SETUP,
    24'h106118};

  event_status_mask_unit i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .i_event(i_event), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
    .o_irq(o_irq), .o_msg_valid(o_msg_valid), .o_msg(o_msg));

  // Free running 50 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic report_and_stop();
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic cmp_msg(input event_unit_pkg::message_t g,
                         input event_unit_pkg::message_t x);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // One classic cycle; bounded wait so a missing ack ends the run
  task automatic wb(input logic we, input logic [23:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_sel <= 4'hf;
    i_wb_dat <= d;
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      report_and_stop();
    end
    @(posedge i_mclk);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
  endtask

  task automatic rd(input logic [23:0] a, input logic [31:0] x);
    rq.push_back(x);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic fire(input logic [31:0] v);
    @(posedge i_mclk);
    i_event <= v;
    @(posedge i_mclk);
    i_event <= 32'h0;
  endtask

  task automatic chk_irq(input logic x);
    @(negedge i_mclk);
    cmp_word({31'h0, o_irq}, {31'h0, x});
  endtask

  task automatic do_reset();
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    repeat (10) @(posedge i_mclk);
    i_rst_b <= 1'b1;
  endtask

  // Watcher: every read answer and every message takes the oldest note
  always @(negedge i_mclk) begin
    if (o_wb_ack === 1'b1 && i_wb_cyc === 1'b1 && i_wb_we === 1'b0) begin
      cmp_word(o_wb_dat, rq.pop_front());
    end
    if (o_msg_valid === 1'b1) begin
      cmp_msg(o_msg, mq.size() ? mq.pop_front() : 'x);
    end
  end

  initial begin
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_sel} = '0;
    {i_wb_adr, i_wb_dat, i_event} = '0;
    i_rst_b = 1'b0;
    seed = 57593;
    r = $random(seed) | 32'h1;
    m = $random(seed) | 32'h1;
    c = $random(seed);
    t = $random(seed);
    e = $random(seed) | 32'h1;
    do_reset();
    foreach (regs[i]) rd(regs[i], 32'h0);
    // Events land with the mask closed: raw only, no interrupt
    fire(r);
    rd(`OFF_RAW_STATE, r);
    rd(`OFF_MASKED_STATE, 32'h0);
    chk_irq(1'b0);
    rd(`OFF_REPEAT_FLAG, 32'h0);
    fire(r);
    rd(`OFF_REPEAT_FLAG, r);
    wb(1'b1, `OFF_REPEAT_FLAG, 32'h0);
    rd(`OFF_REPEAT_FLAG, 32'h0);
    wb(1'b1, `OFF_MASK_ENABLE, m);
    rd(`OFF_MASKED_STATE, r & m);
    chk_irq(1'b1);
    // Zeros clear, ones leave bits alone
    wb(1'b1, `OFF_RAW_STATE, ~c);
    raw = r & ~c;
    rd(`OFF_RAW_STATE, raw);
    wb(1'b1, `OFF_SW_TRIGGER, t);
    raw = raw | (t & m);
    rd(`OFF_RAW_STATE, raw);
    rd(`OFF_SW_TRIGGER, 32'h0);
    // Messages off: any pulse here finds no note and mismatches
    wb(1'b1, `OFF_MSG_SETUP, 32'h5a5a0002);
    fire(e);
    wb(1'b1, `OFF_MSG_SETUP, 32'h5a5a0003);
    rd(`OFF_MSG_SETUP, 32'h5a5a0003);
    mq.push_back(event_unit_pkg::message_t'{e & m, 16'h5a5a, 1'b1});
    fire(e);
    wb(1'b1, `OFF_RAW_STATE, 32'h0);
    rd(`OFF_MASKED_STATE, 32'h0);
    chk_irq(1'b0);
    // Reset in mid-run clears the mask again
    do_reset();
    rd(`OFF_MASK_ENABLE, 32'h0);
    repeat (3) @(posedge i_mclk);
    cmp_word(mq.size(), 32'h0);
    report_and_stop();
  end
endmodule

// ### event_unit_pkg.sv
package event_unit_pkg;

  // Wishbone answer sequencing
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

  // Layout of the message setup register
  typedef struct packed {
    logic [15:0] dest_id;
    logic [13:0] unused;
    logic large_transport;
    logic msg_enable;
  } setup_t;

  // One outgoing event message request
  typedef struct packed {
    logic [31:0] events;
    logic [15:0] dest_id;
    logic large_transport;
  } message_t;

endpackage
